// [src/csw_unit.sv]
// chip-select decode and wait-state sequencer with apb registers
// assumes bus cycle requests and apb come from sys_clk logic
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module csw_unit
   import csw_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb slave
   input csw_apb_t apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // processor bus cycle
   input csw_cyc_t cyc,
   output logic cycle_busy,
   output logic cycle_done,
   // ready pins
   input wire logic async_ready_in,
   input wire logic sync_ready_in,
   // select pins
   output csw_sel_t sel
);
   // ============================================
   // state
   typedef struct packed {
      csw_state_t st;
      logic [3:0] wcnt;
      logic first;
      logic seen;
      logic ign;
      logic hit_top;
      logic hit_bot;
      logic [3:0] hit_mid;
      logic [N_PER-1:0] hit_per;
      logic dram;
      logic off;
      logic [1:0] a21;
      logic [15:0] top_region_cfg;
      logic [15:0] bottom_region_cfg;
      logic [15:0] periph_base_cfg;
      logic [15:0] mid_region_cfg;
      logic [15:0] mid_periph_aux_cfg;
      logic bot_en;
      logic mid_wr;
      logic aux_wr;
      logic per_wr;
      logic ar1;
      logic ar2;
      logic sr1;
      logic sr2;
      logic ack;
      logic [31:0] rdata;
      csw_sel_t sel;
   } csw_q_t;

   csw_q_t q;
   csw_q_t next_q;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   function automatic logic [2:0] hi_bit(input logic [6:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   // ============================================
   // address decode
   logic [15:0] ucfg;
   logic [15:0] lcfg;
   logic [15:0] pcfg;
   logic [15:0] mcfg;
   logic [15:0] xcfg;
   logic mid_en;
   logic per_en;
   logic top_hit;
   logic bot_hit;
   logic [2:0] msz;
   logic [19:0] msize;
   logic [19:0] moff;
   logic mid_in;
   logic [1:0] mid_idx;
   logic [3:0] mid_hit;
   logic [19:0] poff;
   logic per_space;
   logic [N_PER-1:0] per_raw;
   logic [N_PER-1:0] per_hit;
   logic rdy;

   assign ucfg = q.top_region_cfg;
   assign lcfg = q.bottom_region_cfg;
   assign pcfg = q.periph_base_cfg;
   assign mcfg = q.mid_region_cfg;
   assign xcfg = q.mid_periph_aux_cfg;
   assign mid_en = q.mid_wr & q.aux_wr; // [R5] [R4]
   assign per_en = q.per_wr & q.aux_wr; // [R5] [R4]
   // top region runs to the last address, lower bound set
   assign top_hit = !cyc.io &&
      cyc.addr[19:16] >= {1'b1, ucfg[F_BND+:3]}; // [R1] [R4]
   assign bot_hit = q.bot_en && !cyc.io &&
      cyc.addr[19:16] <= {1'b0, lcfg[F_BND+:3]}; // [R2]
   assign msz = hi_bit(xcfg[F_MSIZE+:7]);
   assign msize = 20'h02000 << msz; // [R3]
   assign moff = cyc.addr - {mcfg[F_MBASE+:7], 13'h0000};
   assign mid_in = mid_en && !cyc.io && moff < msize;
   assign mid_idx = 2'(moff >> (5'(msz) + 5'd11));
   assign mid_hit = mid_in ? (4'h1 << mid_idx) : 4'h0;
   assign poff = cyc.addr - {pcfg[F_PBASE+:10], 10'h000};
   // io-space periph compares only against io cycles
   assign per_space = cyc.io != xcfg[F_MEM]; // [R23]

   genvar gi;
   generate
      for (gi = 0; gi < N_PER; gi++) begin : g_per
         // fixed 256-byte block per select
         assign per_raw[gi] = per_en && per_space &&
            poff[19:PER_SHIFT] == 12'(gi); // [R3] [R22]
      end
   endgenerate

   // upper pair idle while its pins carry latched A2-A1
   assign per_hit = {per_raw[6:5] & {2{xcfg[F_EXT]}},
                     per_raw[4:0]}; // [R18]
   assign rdy = q.ar2 | q.sr2; // [R13]

   // ============================================
   // cycle configuration merge
   logic [3:0] ew;
   logic ei;
   logic dram_hit;
   logic off_hit;

   always_comb begin
      ew = 4'h0;
      ei = 1'b1;
      if (top_hit) begin
         ew = (ew > {2'b00, ucfg[1:0]}) ? ew : {2'b00, ucfg[1:0]}; // [R10]
         ei = ei & ucfg[F_IGN]; // [R8]
      end
      if (bot_hit) begin
         ew = (ew > {2'b00, lcfg[1:0]}) ? ew : {2'b00, lcfg[1:0]};
         // mismatched overlaps merge; a stall is left to software
         ei = ei & lcfg[F_IGN]; // [R19]
      end
      if (|mid_hit) begin
         // in force whether pins are selects or io
         ew = (ew > {2'b00, mcfg[1:0]}) ? ew : {2'b00, mcfg[1:0]}; // [R17]
         ei = ei & mcfg[F_IGN];
      end
      if (|per_hit[3:0]) begin
         // high bit adds twelve, so the field reaches fifteen
         ew = (ew > {{2{pcfg[F_HIW]}}, pcfg[1:0]}) ? ew :
              {{2{pcfg[F_HIW]}}, pcfg[1:0]}; // [R9] [R11]
         ei = ei & pcfg[F_IGN];
      end
      if (|per_hit[6:4]) begin
         ew = (ew > {2'b00, xcfg[1:0]}) ? ew : {2'b00, xcfg[1:0]}; // [R9]
         ei = ei & xcfg[F_IGN];
      end
      // internal block: zero waits, no external ready
      if (cyc.internal_register_block) begin
         ew = 4'h0; // [R15]
         ei = 1'b1;
      end
      dram_hit = (top_hit & ucfg[F_DEN]) | (bot_hit & lcfg[F_DEN]);
      off_hit = (top_hit & ucfg[F_OFF]) | (bot_hit & lcfg[F_OFF]); // [R16]
   end

   // ============================================
   // apb decode
   logic [7:0] idx;
   logic map_ok;
   logic acc;
   logic wr_fire;
   logic [31:0] rd_val;

   assign idx = apb.paddr[9:2];
   assign acc = apb.psel & apb.penable;
   assign wr_fire = acc & q.ack & apb.pwrite & map_ok;

   always_comb begin
      map_ok = 1'b1;
      rd_val = 32'h0;
      if (apb.paddr[11:10] != 2'b00 || apb.paddr[1:0] != 2'b00) begin
         map_ok = 1'b0;
      end else if (idx == IDX_TOP) begin
         rd_val = {16'h0, ucfg};
      end else if (idx == IDX_BOT) begin
         rd_val = {16'h0, lcfg};
      end else if (idx == IDX_PER) begin
         rd_val = {16'h0, pcfg};
      end else if (idx == IDX_MID) begin
         rd_val = {16'h0, mcfg};
      end else if (idx == IDX_AUX) begin
         rd_val = {16'h0, xcfg};
      end else if (idx == IDX_STAT) begin
         rd_val = {24'h0, q.ign, q.st, q.per_wr, q.aux_wr,
                   q.mid_wr, q.bot_en};
      end else begin
         map_ok = 1'b0;
      end
   end

   // ============================================
   // next state
   logic act;
   logic cas_on;

   always_comb begin
      next_q = q;
      act = 1'b0;
      cas_on = 1'b0;
      // ready pin synchronisers
      next_q.ar1 = async_ready_in;
      next_q.ar2 = q.ar1;
      next_q.sr1 = sync_ready_in;
      next_q.sr2 = q.sr1;
      // registers
      next_q.ack = acc & !q.ack;
      if (acc && !q.ack) begin
         next_q.rdata = rd_val;
      end
      if (wr_fire) begin
         if (idx == IDX_TOP) begin
            next_q.top_region_cfg = merge(ucfg, apb.pwdata, apb.pstrb);
         end else if (idx == IDX_BOT) begin
            next_q.bottom_region_cfg = merge(lcfg, apb.pwdata, apb.pstrb);
            next_q.bot_en = 1'b1; // [R5]
         end else if (idx == IDX_PER) begin
            next_q.periph_base_cfg = merge(pcfg, apb.pwdata, apb.pstrb);
            next_q.per_wr = 1'b1;
         end else if (idx == IDX_MID) begin
            next_q.mid_region_cfg = merge(mcfg, apb.pwdata, apb.pstrb);
            next_q.mid_wr = 1'b1;
         end else if (idx == IDX_AUX) begin
            next_q.mid_periph_aux_cfg = merge(xcfg, apb.pwdata, apb.pstrb);
            next_q.aux_wr = 1'b1;
         end
      end
      // bus cycle sequencer
      case (q.st)
         ST_IDLE: begin
            if (cyc.start) begin
               next_q.st = ST_T1;
               next_q.wcnt = ew;
               next_q.ign = ei;
               next_q.seen = 1'b0;
               next_q.first = 1'b0;
               next_q.hit_top = top_hit;
               next_q.hit_bot = bot_hit;
               next_q.hit_mid = mid_hit;
               next_q.hit_per = per_hit;
               next_q.dram = dram_hit;
               next_q.off = off_hit;
               next_q.a21 = cyc.addr[2:1];
            end
         end
         ST_T1: begin
            next_q.st = ST_T2;
         end
         ST_T2: begin
            next_q.st = ST_T3;
         end
         ST_T3: begin
            // programmed waits always run before ready counts
            if (q.wcnt != 4'h0) begin
               next_q.st = ST_TW; // [R12]
               next_q.first = 1'b1;
            end else if (q.ign || rdy) begin
               next_q.st = ST_T4; // [R8]
            end else begin
               next_q.st = ST_WRDY;
            end
         end
         ST_TW: begin
            next_q.first = 1'b0;
            next_q.wcnt = q.wcnt - 4'h1;
            if (q.first) begin
               next_q.seen = rdy; // [R12]
            end
            if (q.wcnt == 4'h1) begin
               if (q.ign || q.seen || (q.first && rdy)) begin
                  next_q.st = ST_T4;
               end else begin
                  next_q.st = ST_WRDY;
               end
            end
         end
         ST_WRDY: begin
            // ready seen: one more wait, then the final state
            if (rdy) begin
               next_q.st = ST_TW; // [R12]
               next_q.wcnt = 4'h1;
               next_q.seen = 1'b1;
            end
         end
         ST_T4: begin
            next_q.st = ST_IDLE;
         end
         default: begin
            next_q.st = ST_IDLE;
         end
      endcase
      // select outputs
      act = next_q.st != ST_IDLE;
      cas_on = act && next_q.st != ST_T1;
      next_q.sel.top_region_select_n =
         !(act & next_q.hit_top & !ucfg[F_DEN]); // [R6]
      next_q.sel.bottom_region_select_n =
         !(act & next_q.hit_bot & !lcfg[F_DEN]); // [R6]
      next_q.sel.mid_region_selects_n =
         ~({4{act}} & next_q.hit_mid); // [R7]
      next_q.sel.lower_periph_selects_n =
         ~({4{act}} & next_q.hit_per[3:0]); // [R7]
      if (!xcfg[F_EXT]) begin
         next_q.sel.upper_periph_selects_n = next_q.a21; // [R18]
      end else begin
         next_q.sel.upper_periph_selects_n =
            ~({2{act}} & next_q.hit_per[6:5]);
      end
      next_q.sel.row_strobe_n = !(act & next_q.dram); // [R20]
      next_q.sel.upper_column_strobe_n =
         !(cas_on & next_q.dram & !(|next_q.hit_per)); // [R20]
      next_q.sel.lower_column_strobe_n =
         !(cas_on & next_q.dram & !(|next_q.hit_per));
      next_q.sel.address_phase_off = next_q.st == ST_T1 && next_q.off;
   end

   // ============================================
   // registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.top_region_cfg <= TOP_RST;
         q.bottom_region_cfg <= CFG_RST;
         q.periph_base_cfg <= CFG_RST;
         q.mid_region_cfg <= CFG_RST;
         q.mid_periph_aux_cfg <= CFG_RST;
         q.sel <= '1;
         q.sel.address_phase_off <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   assign prdata = q.rdata;
   assign pready = q.ack;
   assign pslverr = q.ack & !map_ok;
   assign sel = q.sel;
   assign cycle_busy = q.st != ST_IDLE;
   assign cycle_done = q.st == ST_T4;

   // ============================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_top_live;
      q.st == ST_IDLE && cyc.start && top_hit && !ucfg[F_DEN]
         |=> !sel.top_region_select_n;
   endproperty
   a_top_live: assert property (p_top_live) else $error("top select missing"); // [R1]

   property p_bot_gate;
      !q.bot_en |-> sel.bottom_region_select_n;
   endproperty
   a_bot_gate: assert property (p_bot_gate) else $error("bottom select early"); // [R4]

   property p_mid_gate;
      !(q.mid_wr && q.aux_wr) |-> &sel.mid_region_selects_n;
   endproperty
   a_mid_gate: assert property (p_mid_gate) else $error("mid select early"); // [R5]

   property p_per_gate;
      !(q.per_wr && q.aux_wr) |-> &sel.lower_periph_selects_n;
   endproperty
   a_per_gate: assert property (p_per_gate) else $error("periph select early"); // [R5]

   property p_fast;
      q.st == ST_IDLE && cyc.start && ei && ew == 4'h0
         |-> ##4 cycle_done;
   endproperty
   a_fast: assert property (p_fast) else $error("zero wait cycle length"); // [R15]

   property p_extend;
      q.st == ST_WRDY && !rdy |=> q.st == ST_WRDY;
   endproperty
   a_extend: assert property (p_extend) else $error("ended without ready"); // [R12]

   property p_extra;
      q.st == ST_WRDY && rdy |=> q.st == ST_TW ##1 cycle_done;
   endproperty
   a_extra: assert property (p_extra) else $error("extra wait missing"); // [R12]

   property p_off;
      q.st == ST_T1 && q.off |-> sel.address_phase_off;
   endproperty
   a_off: assert property (p_off) else $error("address phase driven"); // [R16]

   property p_cas;
      |(~sel.lower_periph_selects_n) |-> sel.upper_column_strobe_n &&
         sel.lower_column_strobe_n;
   endproperty
   a_cas: assert property (p_cas) else $error("column strobe with periph"); // [R20]

   property p_ack;
      acc && !q.ack |=> pready ##1 !pready;
   endproperty
   a_ack: assert property (p_ack) else $error("apb answer timing"); // [R5]

   c_wait: cover property (q.st == ST_TW ##1 cycle_done);
   c_wrdy: cover property (q.st == ST_WRDY ##1 q.st == ST_TW);
   c_per: cover property (!sel.lower_periph_selects_n[0]);
endmodule

// [src/csw_pkg.sv]
// constants and types of the chip-select and wait-state unit
// assumes an apb master and a processor bus on sys_clk
// Behaviour
// R1: top region always ends at FFFFFh
// R2: bottom region always starts at zero
// R3: periph blocks 256 bytes; mid base, size programmable
// R4: only top select live before configuration writes
// R5: bottom on write; mid, periph need aux too
// R6: top/bottom assert early with plain address
// R7: mid/periph selects assert with address phase
// R8: ready-ignore bit set means external ready ignored
// R9: lower periph 0-15 waits, others 0-3
// R10: two-bit wait field counts waits directly
// R11: extra high wait bit for lower periph
// R12: waits first, sample ready, extend, one more
// R13: async ready rising edge synchronised, active high
// R14: software keeps overlapping selects identically configured
// R15: internal register block: zero waits, ready ignored
// R16: address-phase-off applies to every overlapping access
// R17: mid/periph wait logic stays in force always; code drops the upper periph pair's waits and ready-ignore in address mode
// R18: hidden fifth periph kept; upper off in address mode
// R19: mismatched overlaps may stall; not prevented
// R20: periph over dram: row strobe, no column strobes
// R21: software gives periph enough waits, 16-bit width
// R22: periph block hides its span of dram
// R23: io-space periph never overlaps memory selects
package csw_pkg;
   // ============================================
   // register indices (byte address is four times)
   localparam logic [7:0] IDX_TOP = 8'ha0;
   localparam logic [7:0] IDX_BOT = 8'ha2;
   localparam logic [7:0] IDX_PER = 8'ha4;
   localparam logic [7:0] IDX_MID = 8'ha6;
   localparam logic [7:0] IDX_AUX = 8'ha8;
   localparam logic [7:0] IDX_STAT = 8'haa;
   localparam logic [15:0] TOP_RST = 16'hf03b;
   localparam logic [15:0] CFG_RST = 16'h0000;
   // ============================================
   // field positions
   localparam int F_BND = 12;
   localparam int F_OFF = 7;
   localparam int F_DEN = 6;
   localparam int F_IGN = 2;
   localparam int F_HIW = 3;
   localparam int F_PBASE = 6;
   localparam int F_MBASE = 9;
   localparam int F_MSIZE = 8;
   localparam int F_EXT = 7;
   localparam int F_MEM = 6;
   localparam int N_PER = 7;
   localparam int PER_SHIFT = 8;
   localparam int MID_SHIFT = 13;
   // ============================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b010,
      ST_T3 = 3'b011,
      ST_TW = 3'b100,
      ST_WRDY = 3'b101,
      ST_T4 = 3'b110
   } csw_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } csw_apb_t;
   typedef struct packed {
      logic start;
      logic io;
      logic internal_register_block;
      logic [19:0] addr;
   } csw_cyc_t;
   typedef struct packed {
      logic top_region_select_n;
      logic bottom_region_select_n;
      logic [3:0] mid_region_selects_n;
      logic [1:0] upper_periph_selects_n;
      logic [3:0] lower_periph_selects_n;
      logic row_strobe_n;
      logic upper_column_strobe_n;
      logic lower_column_strobe_n;
      logic address_phase_off;
   } csw_sel_t;
endpackage

// [bench/csw_ready_model.sv]
// ready behaviour of the external memories and peripherals
// assumes active-low selects from the unit and a free-running sys_clk
`timescale 1ns/1ps
module csw_ready_model
   import csw_pkg::*;
(
   // clock and behaviour
   input wire logic sys_clk,
   input wire logic [1:0] mode,
   // selects seen
   input csw_sel_t sel,
   // ready pins
   output logic async_ready_in,
   output logic sync_ready_in
);
   logic hit;
   int cnt = 0;
   // upper pair may carry latched address bits, so it is not counted
   assign hit = ~&{sel.top_region_select_n, sel.bottom_region_select_n, sel.mid_region_selects_n,
      sel.lower_periph_selects_n, sel.row_strobe_n};
   // ============================================
   // mode 1 ready tied high, mode 2 slow device, mode 0 never ready
   always @(posedge sys_clk) begin
      cnt <= hit ? cnt + 1 : 0;
      sync_ready_in <= (mode == 2'h1);
   end
   // async edge lands away from the clock edge
   always @(posedge sys_clk) begin
      async_ready_in <= #3 (mode == 2'h1) || (mode == 2'h2 && hit && cnt >= 5);
   end
endmodule

// [bench/chip_select_wait_state_unit_tb.sv]
// self-checking bench of the chip-select and wait-state unit
// assumes csw_pkg and the ready model; selects sampled 1 ns after edges
`timescale 1ns/1ps
module chip_select_wait_state_unit_tb
   import csw_pkg::*;
;
   typedef struct packed {
      logic [11:0] wa;
      logic [15:0] wd;
      logic [1:0] md;
      logic io;
      logic irb;
      logic [19:0] ad;
      logic [14:0] sv;
      logic ap;
      logic [4:0] cy;
      logic gt;
   } csw_row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   csw_apb_t apb_s = '0;
   csw_cyc_t cyc = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cycle_busy;
   logic cycle_done;
   logic async_ready_in;
   logic sync_ready_in;
   csw_sel_t sel;
   logic [1:0] pmode = 2'h1;
   logic [14:0] selvec;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] r;
   logic e;
   logic ap;
   logic [14:0] v;
   logic [14:0] v1;
   int n;
   // write, data, ready mode, io, internal, address, selects, addr off, cycles, longer
   csw_row_t rows [19] = '{
      '{12'h0, 16'h0, 2'h1, 1'h0, 1'h0, 20'hf1234, 15'h3f7f, 1'h0, 5'h07, 1'h0},
      '{12'h0, 16'h0, 2'h2, 1'h0, 1'h0, 20'hf0000, 15'h3e7f, 1'h0, 5'h07, 1'h1},
      '{12'h0, 16'h0, 2'h0, 1'h0, 1'h1, 20'hf1000, 15'h0000, 1'h0, 5'h04, 1'h0},
      '{12'h0, 16'h0, 2'h1, 1'h0, 1'h0, 20'h00100, 15'h7e7f, 1'h0, 5'h00, 1'h0},
      '{12'h288, 16'h0086, 2'h0, 1'h0, 1'h0, 20'h00100, 15'h5e7f, 1'h1, 5'h06, 1'h0},
      '{12'h0, 16'h0, 2'h1, 1'h0, 1'h0, 20'h20000, 15'h7e7f, 1'h0, 5'h00, 1'h0},
      '{12'h280, 16'hc006, 2'h0, 1'h0, 1'h0, 20'hc0000, 15'h3e7f, 1'h0, 5'h06, 1'h0},
      '{12'h0, 16'h0, 2'h1, 1'h0, 1'h0, 20'hbfff0, 15'h7e7f, 1'h0, 5'h00, 1'h0},
      '{12'h298, 16'h4004, 2'h1, 1'h0, 1'h0, 20'h40000, 15'h7e7f, 1'h0, 5'h00, 1'h0},
      '{12'h290, 16'h1007, 2'h1, 1'h0, 1'h0, 20'h10000, 15'h7e7f, 1'h0, 5'h00, 1'h0},
      '{12'h2a0, 16'h01c4, 2'h0, 1'h0, 1'h0, 20'h40000, 15'h7dff, 1'h0, 5'h04, 1'h0},
      '{12'h0, 16'h0, 2'h0, 1'h0, 1'h0, 20'h41ffe, 15'h6fff, 1'h0, 5'h04, 1'h0},
      '{12'h0, 16'h0, 2'h0, 1'h0, 1'h0, 20'h10300, 15'h7fbf, 1'h0, 5'h07, 1'h0},
      '{12'h0, 16'h0, 2'h0, 1'h0, 1'h0, 20'h10500, 15'h7f7f, 1'h0, 5'h04, 1'h0},
      '{12'h0, 16'h0, 2'h0, 1'h0, 1'h0, 20'h10400, 15'h7fff, 1'h0, 5'h04, 1'h0},
      '{12'h0, 16'h0, 2'h1, 1'h1, 1'h0, 20'h10000, 15'h7fff, 1'h0, 5'h00, 1'h0},
      '{12'h290, 16'h100f, 2'h0, 1'h0, 1'h0, 20'h10000, 15'h7ff7, 1'h0, 5'h13, 1'h0},
      '{12'h280, 16'hc046, 2'h0, 1'h0, 1'h0, 20'hc0000, 15'h7ff8, 1'h0, 5'h06, 1'h0},
      '{12'h290, 16'hc007, 2'h0, 1'h0, 1'h0, 20'hc0100, 15'h7feb, 1'h0, 5'h07, 1'h0}
   };
   assign selvec = {sel.top_region_select_n, sel.bottom_region_select_n, sel.mid_region_selects_n,
      sel.upper_periph_selects_n, sel.lower_periph_selects_n, sel.row_strobe_n,
      sel.upper_column_strobe_n, sel.lower_column_strobe_n};
   csw_unit uut (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .apb(apb_s),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .cyc(cyc),
      .cycle_busy(cycle_busy),
      .cycle_done(cycle_done),
      .async_ready_in(async_ready_in),
      .sync_ready_in(sync_ready_in),
      .sel(sel)
   );
   csw_ready_model far_side (
      .sys_clk(sys_clk),
      .mode(pmode),
      .sel(sel),
      .async_ready_in(async_ready_in),
      .sync_ready_in(sync_ready_in)
   );
   always #5 sys_clk = ~sys_clk;
   // ============================================
   // shared tasks
   task chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      apb_s <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {16'h0, d}, pstrb: 4'h3};
      @(posedge sys_clk);
      apb_s.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      apb_s <= '0;
   endtask
   // hold keeps start up into T1, where it must be refused
   task run_cyc(input logic io, input logic irb, input logic [19:0] ad, input logic hold);
      @(posedge sys_clk);
      cyc <= '{start: 1'b1, io: io, internal_register_block: irb, addr: ad};
      @(posedge sys_clk);
      cyc.start <= hold;
      n = 1;
      #1;
      ap = sel.address_phase_off;
      v1 = selvec;
      @(posedge sys_clk);
      cyc.start <= 1'b0;
      n = 2;
      #1;
      v = selvec;
      while (cycle_done !== 1'b1) begin
         @(posedge sys_clk);
         n++;
         #1;
      end
   endtask
   task end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ============================================
   // main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 19; i++) begin
         if (rows[i].wa != 12'h0) apb(1'b1, rows[i].wa, rows[i].wd);
         pmode <= rows[i].md;
         run_cyc(rows[i].io, rows[i].irb, rows[i].ad, 1'b0);
         if (rows[i].sv != 15'h0) chk(32'(v), 32'(rows[i].sv));
         if (rows[i].sv != 15'h0) chk(32'(v1[14:3]), 32'(rows[i].sv[14:3]));
         chk(32'(ap), 32'(rows[i].ap));
         if (rows[i].cy != 5'h0) chk(32'(rows[i].gt ? n > rows[i].cy : n == rows[i].cy), 32'h1);
         $display("row %0d done", i);
      end
      apb(1'b0, 12'h288, 16'h0);
      chk(r, 32'h0086);
      apb(1'b0, 12'h2fc, 16'h0);
      chk(r, 32'h0);
      chk(32'(e), 32'h1);
      $display("register test done");
      run_cyc(1'b0, 1'b0, 20'h40000, 1'b1);
      chk(32'(n), 32'h4);
      @(posedge sys_clk);
      #1;
      chk(32'(cycle_busy), 32'h0);
      $display("refused start test done");
      @(posedge sys_clk);
      cyc <= '{start: 1'b1, io: 1'b0, internal_register_block: 1'b0, addr: 20'h10000};
      @(posedge sys_clk);
      cyc.start <= 1'b0;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(32'(selvec), 32'h7fff);
      chk(32'(cycle_busy), 32'h0);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h280, 16'h0);
      chk(r, 32'hf03b);
      apb(1'b0, 12'h288, 16'h0);
      chk(r, 32'h0);
      pmode <= 2'h1;
      run_cyc(1'b0, 1'b0, 20'h00100, 1'b0);
      chk(32'(v), 32'h7e7f);
      run_cyc(1'b0, 1'b0, 20'hf8000, 1'b0);
      chk(32'(v), 32'h3e7f);
      chk(32'(n), 32'h7);
      $display("reset test done");
      end_of_test();
   end
   initial begin
      #300000;
      bad_count++;
      end_of_test();
   end
endmodule
